// File: mie_pkg.sv
`default_nettype none
package mie_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 16;

    // ------------------------------------------------------------
    // addresses
    // ------------------------------------------------------------
    localparam logic [15:0] STACK_PAGE = 16'h0100;
    localparam logic [15:0] VEC_LO_ADDR = 16'hFFFE;
    localparam logic [15:0] VEC_HI_ADDR = 16'hFFFF;

    // ------------------------------------------------------------
    // status byte layout and reset values
    // ------------------------------------------------------------
    localparam int unsigned NEG_BIT = 7;
    localparam int unsigned BRK_BIT = 4;
    localparam int unsigned MASK_BIT = 2;
    localparam int unsigned SIGN_BIT = 7;
    localparam logic MASK_RST = 1'b1;
    localparam logic NEG_RST = 1'b0;

    // ------------------------------------------------------------
    // entry sequence timing
    // ------------------------------------------------------------
    localparam int unsigned ENTRY_CYCLES = 7;
    localparam logic [7:0] SP_STEP = 8'h01;
    localparam logic [7:0] SP_PUSHES = 8'h03;

    // entry sequence steps, one per bus cycle
    typedef enum logic [2:0] {
        MIE_IDLE,
        MIE_DUMMY1,
        MIE_DUMMY2,
        MIE_PUSH_PCH,
        MIE_PUSH_PCL,
        MIE_PUSH_STAT,
        MIE_VEC_LO,
        MIE_VEC_HI
    } mie_step_t;
endpackage
`default_nettype wire

// File: mie_flag_if.sv
`timescale 1ns/1ns
`default_nettype none
interface mie_flag_if;
    logic clear_mask_instruction;
    logic set_mask_instruction;
    logic entry_mask_set;
    logic load_accumulator;
    logic [7:0] load_value;
    logic mask;
    logic negative;

    modport core (
        output clear_mask_instruction,
        output set_mask_instruction,
        output entry_mask_set,
        output load_accumulator,
        output load_value,
        input mask,
        input negative
    );
    modport flags (
        input clear_mask_instruction,
        input set_mask_instruction,
        input entry_mask_set,
        input load_accumulator,
        input load_value,
        output mask,
        output negative
    );
endinterface
`default_nettype wire

// File: mie_flags.sv
`timescale 1ns/1ns
`default_nettype none
module mie_flags (
    input wire logic core_clk,
    input wire logic sys_rst,
    mie_flag_if.flags fl
);
    logic mask_q, mask_d;
    logic neg_q, neg_d;

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    // entry set wins over a clear so a held line cannot retrigger
    always_comb begin
        mask_d = mask_q;
        if (fl.clear_mask_instruction) begin
            mask_d = 1'b0;
        end
        if (fl.set_mask_instruction || fl.entry_mask_set) begin
            mask_d = 1'b1;
        end
        neg_d = neg_q;
        if (fl.load_accumulator) begin
            neg_d = fl.load_value[mie_pkg::SIGN_BIT];
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // mask starts on so nothing is taken before software is ready
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mask_q <= mie_pkg::MASK_RST;
            neg_q <= mie_pkg::NEG_RST;
        end else begin
            mask_q <= mask_d;
            neg_q <= neg_d;
        end
    end

    assign fl.mask = mask_q;
    assign fl.negative = neg_q;
endmodule // mie_flags
`default_nettype wire

// File: mie_entry.sv
// Behaviour
// - one or many sources holding the shared low line give the same response.
// - acceptance pushes program counter and status, then loads the fixed vector.
// - pending requests are recognised only at the end of an instruction.
// - entry takes seven cycles; worst case to handler is fourteen.
// - clearing the mask with the line still low takes an interrupt next.
// - while the mask is set, maskable requests of any priority are ignored.
// - loading the accumulator copies bit 7 into the negative flag.
// - the request input is level sensitive and active when low.
// - taking an interrupt sets the mask automatically.
`timescale 1ns/1ns
`default_nettype none
module mie_entry (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic irq_n,
    input wire logic instr_end,
    input wire logic [15:0] pc_cur,
    input wire logic [7:0] sp_cur,
    input wire logic [7:0] status_in,
    input wire logic clear_mask_instruction,
    input wire logic set_mask_instruction,
    input wire logic load_accumulator,
    input wire logic [7:0] load_value,
    input wire logic [7:0] mem_rdata,
    output logic [15:0] bus_addr_q,
    output logic [7:0] bus_wdata_q,
    output logic bus_read_q,
    output logic bus_write_q,
    output logic entry_active_q,
    output logic int_taken_q,
    output logic pc_load_q,
    output logic [15:0] pc_new_q,
    output logic sp_load_q,
    output logic [7:0] sp_new_q,
    output var logic mask_flag_q,
    output var logic negative_flag_q
);
    mie_flag_if fl ();

    mie_pkg::mie_step_t step_q, step_d;
    logic [15:0] pc_save_q, pc_save_d;
    logic [7:0] sp_save_q, sp_save_d;
    logic [7:0] stat_save_q, stat_save_d;
    logic [7:0] vec_lo_q, vec_lo_d;
    logic [15:0] bus_addr_d;
    logic [7:0] bus_wdata_d;
    logic bus_read_d, bus_write_d, entry_active_d, int_taken_d;
    logic pc_load_d, sp_load_d;
    logic [15:0] pc_new_d;
    logic [7:0] sp_new_d;
    logic request;
    logic mask_open;
    logic accept;

    // ------------------------------------------------------------
    // flag keeper
    // ------------------------------------------------------------
    assign fl.clear_mask_instruction = clear_mask_instruction;
    assign fl.set_mask_instruction = set_mask_instruction;
    assign fl.entry_mask_set = (step_q == mie_pkg::MIE_PUSH_STAT);
    assign fl.load_accumulator = load_accumulator;
    assign fl.load_value = load_value;

    mie_flags u_flags (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .fl(fl)
    );

    assign mask_flag_q = fl.mask;
    assign negative_flag_q = fl.negative;

    // ------------------------------------------------------------
    // acceptance
    // ------------------------------------------------------------
    // the line is one wired level, so any number of sources looks alike
    assign request = ~irq_n;
    // a mask clear ending this instruction opens the gate at once
    assign mask_open = (~fl.mask | clear_mask_instruction) & ~set_mask_instruction;
    // sampled only at instruction end; mid-instruction requests wait
    assign accept = instr_end & request & mask_open & (step_q == mie_pkg::MIE_IDLE);

    // stack address of a push, counting down from the captured pointer
    function automatic logic [15:0] mie_stack_addr(input logic [7:0] sp, input logic [7:0] depth);
        logic [7:0] slot;
        slot = sp - depth;
        return mie_pkg::STACK_PAGE | {8'h00, slot};
    endfunction

    // ------------------------------------------------------------
    // entry sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        step_d = step_q;
        pc_save_d = pc_save_q;
        sp_save_d = sp_save_q;
        stat_save_d = stat_save_q;
        vec_lo_d = vec_lo_q;
        int_taken_d = 1'b0;
        pc_load_d = 1'b0;
        pc_new_d = pc_new_q;
        sp_load_d = 1'b0;
        sp_new_d = sp_new_q;
        unique case (step_q)
            mie_pkg::MIE_IDLE: begin
                if (accept) begin
                    step_d = mie_pkg::MIE_DUMMY1;
                    int_taken_d = 1'b1;
                    pc_save_d = pc_cur;
                    sp_save_d = sp_cur;
                    stat_save_d = status_in;
                    stat_save_d[mie_pkg::NEG_BIT] = fl.negative;
                    stat_save_d[mie_pkg::MASK_BIT] = ~mask_open; // status as before entry
                    stat_save_d[mie_pkg::BRK_BIT] = 1'b0; // hardware entry, not break
                end
            end
            mie_pkg::MIE_DUMMY1: step_d = mie_pkg::MIE_DUMMY2;
            mie_pkg::MIE_DUMMY2: step_d = mie_pkg::MIE_PUSH_PCH;
            mie_pkg::MIE_PUSH_PCH: step_d = mie_pkg::MIE_PUSH_PCL;
            mie_pkg::MIE_PUSH_PCL: step_d = mie_pkg::MIE_PUSH_STAT;
            mie_pkg::MIE_PUSH_STAT: step_d = mie_pkg::MIE_VEC_LO;
            mie_pkg::MIE_VEC_LO: begin
                step_d = mie_pkg::MIE_VEC_HI;
                vec_lo_d = mem_rdata;
            end
            mie_pkg::MIE_VEC_HI: begin
                // seventh cycle ends; the next fetch is the handler's first opcode
                step_d = mie_pkg::MIE_IDLE;
                pc_load_d = 1'b1;
                pc_new_d = {mem_rdata, vec_lo_q};
                sp_load_d = 1'b1;
                sp_new_d = sp_save_q - mie_pkg::SP_PUSHES;
            end
        endcase
    end

    // ------------------------------------------------------------
    // bus cycle of the coming step
    // ------------------------------------------------------------
    // decoded from the next step so the bus pins leave flip-flops aligned
    always_comb begin
        bus_addr_d = pc_save_d;
        bus_wdata_d = 8'h00;
        bus_read_d = 1'b0;
        bus_write_d = 1'b0;
        entry_active_d = (step_d != mie_pkg::MIE_IDLE);
        unique case (step_d)
            mie_pkg::MIE_IDLE: begin
                bus_addr_d = 16'h0000;
            end
            mie_pkg::MIE_DUMMY1, mie_pkg::MIE_DUMMY2: begin
                // opcode fetches are discarded, program counter is not advanced
                bus_read_d = 1'b1;
            end
            mie_pkg::MIE_PUSH_PCH: begin
                bus_addr_d = mie_stack_addr(sp_save_d, 8'h00);
                bus_wdata_d = pc_save_d[15:8];
                bus_write_d = 1'b1;
            end
            mie_pkg::MIE_PUSH_PCL: begin
                bus_addr_d = mie_stack_addr(sp_save_d, mie_pkg::SP_STEP);
                bus_wdata_d = pc_save_d[7:0];
                bus_write_d = 1'b1;
            end
            mie_pkg::MIE_PUSH_STAT: begin
                bus_addr_d = mie_stack_addr(sp_save_d, mie_pkg::SP_STEP + mie_pkg::SP_STEP);
                bus_wdata_d = stat_save_d;
                bus_write_d = 1'b1;
            end
            mie_pkg::MIE_VEC_LO: begin
                bus_addr_d = mie_pkg::VEC_LO_ADDR;
                bus_read_d = 1'b1;
            end
            mie_pkg::MIE_VEC_HI: begin
                bus_addr_d = mie_pkg::VEC_HI_ADDR;
                bus_read_d = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            step_q <= mie_pkg::MIE_IDLE;
            pc_save_q <= 16'h0000;
            sp_save_q <= 8'h00;
            stat_save_q <= 8'h00;
            vec_lo_q <= 8'h00;
            bus_addr_q <= 16'h0000;
            bus_wdata_q <= 8'h00;
            bus_read_q <= 1'b0;
            bus_write_q <= 1'b0;
            entry_active_q <= 1'b0;
            int_taken_q <= 1'b0;
            pc_load_q <= 1'b0;
            pc_new_q <= 16'h0000;
            sp_load_q <= 1'b0;
            sp_new_q <= 8'h00;
        end else begin
            step_q <= step_d;
            pc_save_q <= pc_save_d;
            sp_save_q <= sp_save_d;
            stat_save_q <= stat_save_d;
            vec_lo_q <= vec_lo_d;
            bus_addr_q <= bus_addr_d;
            bus_wdata_q <= bus_wdata_d;
            bus_read_q <= bus_read_d;
            bus_write_q <= bus_write_d;
            entry_active_q <= entry_active_d;
            int_taken_q <= int_taken_d;
            pc_load_q <= pc_load_d;
            pc_new_q <= pc_new_d;
            sp_load_q <= sp_load_d;
            sp_new_q <= sp_new_d;
        end
    end
endmodule // mie_entry
`default_nettype wire

// File: mie_periph_model.sv
`timescale 1ns/1ns
`default_nettype none
module mie_periph_model #(
    parameter int N = 2
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [N-1:0] raise,
    input wire logic [N-1:0] data_read,
    output var logic [N-1:0] pending,
    output wire logic irq_n
);
    // ------------------------------------------------------------
    // peripheral status registers
    // ------------------------------------------------------------
    // only the request bit is modelled; the other status bits stay zero
    logic [7:0] status_q [N];

    // a data transfer clears the request, otherwise it is held until served
    always_ff @(posedge core_clk or posedge sys_rst) begin
        for (int i = 0; i < N; i++) begin
            if (sys_rst) status_q[i] <= 8'h00;
            else if (data_read[i]) status_q[i][7] <= 1'b0;
            else if (raise[i]) status_q[i][7] <= 1'b1;
        end
    end

    // request flag sits in bit 7 of each status byte
    always_comb begin
        for (int i = 0; i < N; i++) pending[i] = status_q[i][7];
    end

    // open-collector outputs: any pending device pulls the shared line low
    assign irq_n = ~|pending;
endmodule // mie_periph_model
`default_nettype wire

// File: mie_entry_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module mie_entry_assertions (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic irq_n,
    input wire logic instr_end,
    input wire logic [15:0] pc_cur,
    input wire logic [7:0] sp_cur,
    input wire logic [7:0] status_in,
    input wire logic clear_mask_instruction,
    input wire logic set_mask_instruction,
    input wire logic load_accumulator,
    input wire logic [7:0] load_value,
    input wire logic [7:0] mem_rdata,
    input wire logic [15:0] bus_addr_q,
    input wire logic [7:0] bus_wdata_q,
    input wire logic bus_read_q,
    input wire logic bus_write_q,
    input wire logic entry_active_q,
    input wire logic int_taken_q,
    input wire logic pc_load_q,
    input wire logic [15:0] pc_new_q,
    input wire logic sp_load_q,
    input wire logic [7:0] sp_new_q,
    input wire logic mask_flag_q,
    input wire logic negative_flag_q
);
    // ------------------------------------------------------------
    // entry sequence checks
    // ------------------------------------------------------------
    // plain signals so that $past sees no slice
    wire logic load_sign = load_value[7];
    wire logic [7:0] pc_hi = pc_cur[15:8];
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_accept;
        instr_end && !irq_n && (!mask_flag_q || clear_mask_instruction) && !set_mask_instruction && !entry_active_q;
    endsequence
    sequence s_pushes;
        bus_write_q [*3];
    endsequence
    sequence s_vector;
        bus_read_q && bus_addr_q == mie_pkg::VEC_LO_ADDR ##1 bus_read_q && bus_addr_q == mie_pkg::VEC_HI_ADDR;
    endsequence

    a_take_at_boundary: assert property (s_accept |=> int_taken_q && entry_active_q)
        else $error("request not taken at boundary");
    a_no_early_take: assert property (int_taken_q |-> $past(instr_end) && !$past(irq_n))
        else $error("entry started off a boundary");
    a_mask_blocks: assert property (mask_flag_q && !clear_mask_instruction |=> !int_taken_q)
        else $error("entry taken while masked");
    a_entry_length: assert property (int_taken_q |-> entry_active_q [*7] ##1 (!entry_active_q && pc_load_q && sp_load_q))
        else $error("entry length wrong");
    a_push_then_vec: assert property (int_taken_q |-> ##2 s_pushes ##1 s_vector)
        else $error("push or vector order wrong");
    a_stack_first: assert property (int_taken_q |-> ##2 bus_addr_q == {8'h01, $past(sp_cur, 3)} && bus_wdata_q == $past(pc_hi, 3))
        else $error("first push wrong");
    a_status_push: assert property (int_taken_q |-> ##4 !bus_wdata_q[4] && bus_wdata_q[7] == negative_flag_q)
        else $error("stacked status wrong");
    a_pc_vector: assert property (pc_load_q |-> pc_new_q == {$past(mem_rdata), $past(mem_rdata, 2)} && sp_new_q == $past(sp_cur, 8) - 8'h03)
        else $error("vector or stack pointer wrong");
    a_mask_on_entry: assert property (int_taken_q ##1 (!clear_mask_instruction) [*5] |=> mask_flag_q)
        else $error("mask not set by entry");
    a_neg_copy: assert property (load_accumulator |=> negative_flag_q == $past(load_sign))
        else $error("negative flag not loaded");
endmodule // mie_entry_assertions
bind mie_entry mie_entry_assertions u_mie_entry_assertions (.core_clk, .sys_rst, .irq_n, .instr_end, .pc_cur,
    .sp_cur, .status_in, .clear_mask_instruction, .set_mask_instruction, .load_accumulator, .load_value,
    .mem_rdata, .bus_addr_q, .bus_wdata_q, .bus_read_q, .bus_write_q, .entry_active_q, .int_taken_q,
    .pc_load_q, .pc_new_q, .sp_load_q, .sp_new_q, .mask_flag_q, .negative_flag_q);
`default_nettype wire

// File: maskable_interrupt_entry_tb.sv
`timescale 1ns/1ns
`default_nettype none
module maskable_interrupt_entry_tb;
    logic core_clk = 1'b0, sys_rst = 1'b1, instr_end = 1'b0, clr = 1'b0, setm = 1'b0, ld = 1'b0;
    logic [15:0] pc_cur = 16'h1234, vec_val = 16'hC000, bus_addr_q, pc_new_q;
    logic [7:0] sp_cur = 8'hFF, status_in = 8'hB5, load_value = 8'h00, mem_rdata = 8'h00, bus_wdata_q, sp_new_q;
    logic [1:0] raise = 2'b00, data_read = 2'b00, pending;
    logic bus_read_q, bus_write_q, entry_active_q, int_taken_q, pc_load_q, sp_load_q, mask_flag_q, negative_flag_q;
    wire logic irq_n;
    int fail_count = 0, checks_done = 0;

    mie_entry u_mie_entry (.core_clk, .sys_rst, .irq_n, .instr_end, .pc_cur, .sp_cur, .status_in,
        .clear_mask_instruction(clr), .set_mask_instruction(setm), .load_accumulator(ld), .load_value,
        .mem_rdata, .bus_addr_q, .bus_wdata_q, .bus_read_q, .bus_write_q, .entry_active_q, .int_taken_q,
        .pc_load_q, .pc_new_q, .sp_load_q, .sp_new_q, .mask_flag_q, .negative_flag_q);
    mie_periph_model u_mie_periph_model (.core_clk, .sys_rst, .raise, .data_read, .pending, .irq_n);

    // ------------------------------------------------------------
    // clock, memory and helpers
    // ------------------------------------------------------------
    initial forever #5 core_clk = ~core_clk;
    // vector bytes on their addresses, the inverted low address byte elsewhere
    always @(negedge core_clk) begin
        mem_rdata <= bus_addr_q == mie_pkg::VEC_LO_ADDR ? vec_val[7:0]
            : bus_addr_q == mie_pkg::VEC_HI_ADDR ? vec_val[15:8] : ~bus_addr_q[7:0];
    end
    // wide enough for the packed flag and address group after reset
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // one-cycle command pulses, all released at the next falling edge
    task pulse(input logic ie, input logic c, input logic s, input logic [1:0] r, input logic [1:0] d);
        @(negedge core_clk);
        {instr_end, clr, setm, raise, data_read} = {ie, c, s, r, d};
        @(negedge core_clk);
        {instr_end, clr, setm, raise, data_read} = '0;
    endtask
    // a boundary that must start a full entry, checked step by step
    task take(input logic c);
        logic [15:0] ea [1:7];
        logic [7:0] st;
        ea = '{pc_cur, pc_cur, {8'h01, sp_cur}, {8'h01, sp_cur - 8'h01}, {8'h01, sp_cur - 8'h02},
            mie_pkg::VEC_LO_ADDR, mie_pkg::VEC_HI_ADDR};
        // stacked status: live negative flag, break clear, mask bit 0 as the gate was open
        st = {negative_flag_q, status_in[6:5], 1'b0, status_in[3], 1'b0, status_in[1:0]};
        @(negedge core_clk);
        {instr_end, clr} = {1'b1, c};
        for (int i = 1; i <= 8; i++) begin
            @(negedge core_clk);
            // a boundary in mid-entry must be ignored although the line is still low
            {instr_end, clr} = {i == 3, 1'b0};
            chk(int_taken_q, i == 1);
            if (i < 8) chk(bus_addr_q, ea[i]);
            if (i < 8) chk(bus_write_q, i >= 3 && i <= 5);
            if (i < 8) chk(bus_read_q, i <= 2 || i >= 6);
            if (i == 5) chk(bus_wdata_q, st);
            if (i == 3) chk(bus_wdata_q, pc_cur[15:8]);
            if (i == 4) chk(bus_wdata_q, pc_cur[7:0]);
            chk(entry_active_q, i < 8);
        end
        chk(pc_load_q, 1'b1);
        chk(sp_load_q, 1'b1);
        chk(pc_new_q, vec_val);
        chk(sp_new_q, sp_cur - 8'h03);
        chk(mask_flag_q, 1'b1);
    endtask
    initial begin
        repeat (2000) @(posedge core_clk);
        fail_count++;
        results();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset_masked;
        chk({mask_flag_q, negative_flag_q, int_taken_q, bus_addr_q}, 19'h40000);
        pulse(1'b0, 1'b0, 1'b0, 2'b01, 2'b00);
        chk(irq_n, 1'b0);
        pulse(1'b1, 1'b0, 1'b0, 2'b00, 2'b00);
        chk(int_taken_q, 1'b0);
        pulse(1'b0, 1'b0, 1'b0, 2'b00, 2'b01);
        chk(irq_n, 1'b1);
        pulse(1'b1, 1'b1, 1'b0, 2'b00, 2'b00);
        chk({mask_flag_q, int_taken_q}, 2'b00);
    endtask
    task t_held_to_boundary;
        pulse(1'b0, 1'b0, 1'b0, 2'b11, 2'b00);
        repeat (6) begin
            @(negedge core_clk);
            chk(int_taken_q, 1'b0);
        end
        take(1'b0);
    endtask
    task t_reentry;
        pulse(1'b1, 1'b0, 1'b0, 2'b00, 2'b00);
        chk(int_taken_q, 1'b0);
        pulse(1'b0, 1'b0, 1'b0, 2'b00, 2'b01);
        chk({irq_n, pending}, 3'b010);
        pc_cur = 16'h0456;
        sp_cur = 8'hFC;
        vec_val = 16'hE1A5;
        take(1'b1);
        pulse(1'b0, 1'b0, 1'b0, 2'b00, 2'b10);
        pulse(1'b1, 1'b1, 1'b0, 2'b00, 2'b00);
        chk({irq_n, int_taken_q, mask_flag_q}, 3'b100);
        pulse(1'b0, 1'b0, 1'b1, 2'b01, 2'b00);
        pulse(1'b1, 1'b0, 1'b0, 2'b00, 2'b00);
        chk({int_taken_q, mask_flag_q}, 2'b01);
        // set and clear in one boundary with the line low: set wins, nothing taken
        pulse(1'b1, 1'b1, 1'b1, 2'b00, 2'b00);
        chk({int_taken_q, mask_flag_q}, 2'b01);
    endtask
    task t_load_sign;
        // ends on a negative value so the stacked status carries a set sign bit
        logic [7:0] vals [4] = '{8'h80, 8'h7F, 8'h40, 8'hC0};
        foreach (vals[i]) begin
            @(negedge core_clk);
            {ld, load_value} = {1'b1, vals[i]};
            @(negedge core_clk);
            ld = 1'b0;
            chk(negative_flag_q, vals[i][7]);
        end
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        sys_rst = 1'b0;
        t_reset_masked();
        t_load_sign();
        t_held_to_boundary();
        t_reentry();
        results();
    end
endmodule // maskable_interrupt_entry_tb
`default_nettype wire
